/* hdl/pgp_pkg.sv */
/*
 * Constants for the two-port GPIO and pin-sharing block: register byte
 * offsets, field positions and reset values.
 * Assumes an AXI4-Lite master with 32-bit data and 8-bit byte addresses.
 */
// Contract
// R1 - A first-port pull-up on pins 0 to 5 is on when its bit is 1, but only while the pin is an input.
// R2 - The two upper bits of the first-port pull-up register always read as 0.
// R3 - With I2C disabled pin 7 is general I/O, with it enabled pin 7 is the open-drain I2C clock line.
// R4 - With I2C disabled pin 6 is general I/O, with it enabled pin 6 is the open-drain I2C data line.
// R5 - A wake mode bit of 1 makes pins 0 to 5 wake inputs, pin 5 also the converter trigger.
// R6 - A general first-port pin drives when its direction bit is 1 and is an input when it is 0.
// R7 - First-port data reads give stored data for outputs and the live pin for inputs.
// R8 - Second-port direction bits 4 to 6 select output at 1 and input at 0, and reset to 0.
// R9 - A nonzero timer output-select field makes second-port pin 6 the timer output.
// R10 - Second-port pins 5 and 4 always feed the timer clock and reset inputs.
// R11 - Second-port data reads give stored data for outputs and the live pin for inputs.
// R12 - Second-port data bit 7 and bits 3 to 0 read as 1, and data bits 6 to 4 reset to 0.
// R13 - After reset every pin is a general input and every pull-up is off.
package pgp_pkg;
    localparam logic [7:0] OFF_P1_DIR = 8'h00;
    localparam logic [7:0] OFF_P1_DATA = 8'h04;
    localparam logic [7:0] OFF_P1_PULLUP = 8'h08;
    localparam logic [7:0] OFF_P1_WAKE = 8'h0c;
    localparam logic [7:0] OFF_I2C_CTRL = 8'h10;
    localparam logic [7:0] OFF_P2_DIR = 8'h14;
    localparam logic [7:0] OFF_P2_DATA = 8'h18;
    localparam logic [7:0] OFF_TIMER_CTRL = 8'h1c;
    localparam int I2C_EN_POS = 0;
    localparam int P2_LSB = 4;
    localparam int P2_W = 3;
    localparam int PU_W = 6;
    localparam int TSEL_W = 4;
    localparam logic [7:0] P1_RST = 8'h00;
    localparam logic [5:0] PU_RST = 6'h00;
    localparam logic [2:0] P2_RST = 3'h0;
    localparam logic [3:0] TSEL_RST = 4'h0;
    localparam logic [3:0] TSEL_GPIO = 4'h0;
    localparam logic [7:0] P2_RSVD_ONES = 8'h8f;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* hdl/pgp_top.sv */
/*
 * Register file and pin multiplexer for two GPIO ports with I2C, wake,
 * trigger and timer sharing, behind an AXI4-Lite slave.
 * Assumes pin levels and peripheral requests are synchronous to aclk.
 */
`timescale 1ns/1ps
`default_nettype none
module pgp_top (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // First port pins
    input wire logic [7:0] p1_pin_in,
    output logic [7:0] p1_pin_out,
    output logic [7:0] p1_pin_oe,
    output logic [5:0] p1_pullup_on,
    // I2C, wake and trigger sharing
    input wire logic i2c_scl_drive_low,
    input wire logic i2c_sda_drive_low,
    output logic i2c_scl_in,
    output logic i2c_sda_in,
    output logic [5:0] wake_in_n,
    output logic converter_trigger_input_n,
    // Second port pins 4 to 6 and timer sharing
    input wire logic [2:0] p2_pin_in,
    output logic [2:0] p2_pin_out,
    output logic [2:0] p2_pin_oe,
    input wire logic timer_output_value,
    output logic timer_clock_input_pin,
    output logic timer_reset_input_pin
);
    logic [7:0] p1_dir_ff, p1_data_ff, p1_wake_ff;
    logic [5:0] p1_pu_ff;
    logic i2c_en_ff;
    logic [2:0] p2_dir_ff, p2_data_ff;
    logic [3:0] tsel_ff;
    logic aw_held_ff, w_held_ff, awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic [7:0] awaddr_ff, araddr_ff;
    logic [7:0] wbyte_ff;
    logic wlane_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff;
    logic [7:0] p1_out_ff, p1_oe_ff;
    logic [5:0] p1_pu_on_ff, wake_n_ff;
    logic scl_in_ff, sda_in_ff, trig_n_ff;
    logic [2:0] p2_out_ff, p2_oe_ff;
    logic tclk_ff, trst_ff;
    logic do_write;
    logic ar_take;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a[7:2] == off[7:2]);
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = hit(a, pgp_pkg::OFF_P1_DIR) | hit(a, pgp_pkg::OFF_P1_DATA) | hit(a, pgp_pkg::OFF_P1_PULLUP) |
                 hit(a, pgp_pkg::OFF_P1_WAKE) | hit(a, pgp_pkg::OFF_I2C_CTRL) | hit(a, pgp_pkg::OFF_P2_DIR) |
                 hit(a, pgp_pkg::OFF_P2_DATA) | hit(a, pgp_pkg::OFF_TIMER_CTRL);
    endfunction

    function automatic logic [7:0] rd_byte(input logic [7:0] a);
        logic [7:0] b;
        b = 8'h00;
        if (hit(a, pgp_pkg::OFF_P1_DATA)) begin
            b = (p1_dir_ff & p1_data_ff) | (~p1_dir_ff & p1_pin_in); // [R7]
        end else if (hit(a, pgp_pkg::OFF_P1_PULLUP)) begin
            b = {2'b00, p1_pu_ff}; // [R2]
        end else if (hit(a, pgp_pkg::OFF_P1_WAKE)) begin
            b = {2'b00, p1_wake_ff[5:0]};
        end else if (hit(a, pgp_pkg::OFF_I2C_CTRL)) begin
            b = {7'h00, i2c_en_ff};
        end else if (hit(a, pgp_pkg::OFF_P2_DATA)) begin
            b = pgp_pkg::P2_RSVD_ONES; // [R12]
            b[6:4] = (p2_dir_ff & p2_data_ff) | (~p2_dir_ff & p2_pin_in); // [R11]
        end else if (hit(a, pgp_pkg::OFF_TIMER_CTRL)) begin
            b = {4'h0, tsel_ff};
        end
        rd_byte = b;
    endfunction

    // Write side: address and data are each taken once, in either order.
    assign do_write = aw_held_ff & w_held_ff & ~bvalid_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b0;
            aw_held_ff <= 1'b0;
            awaddr_ff <= 8'h00;
        end else if (awready_ff) begin
            awready_ff <= 1'b0;
            aw_held_ff <= 1'b1;
            awaddr_ff <= awaddr;
        end else if (do_write) begin
            aw_held_ff <= 1'b0;
        end else if (awvalid & ~aw_held_ff & ~bvalid_ff) begin
            awready_ff <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_ff <= 1'b0;
            w_held_ff <= 1'b0;
            wbyte_ff <= 8'h00;
            wlane_ff <= 1'b0;
        end else if (wready_ff) begin
            wready_ff <= 1'b0;
            w_held_ff <= 1'b1;
            wbyte_ff <= wdata[7:0];
            wlane_ff <= wstrb[0];
        end else if (do_write) begin
            w_held_ff <= 1'b0;
        end else if (wvalid & ~w_held_ff & ~bvalid_ff) begin
            wready_ff <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= pgp_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= mapped(awaddr_ff) ? pgp_pkg::RESP_OKAY : pgp_pkg::RESP_SLVERR;
        end else if (bvalid_ff & bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // Only byte lane 0 carries register data; the registers are byte wide.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            p1_dir_ff <= pgp_pkg::P1_RST; // [R13]
            p1_data_ff <= pgp_pkg::P1_RST;
            p1_wake_ff <= pgp_pkg::P1_RST;
            p1_pu_ff <= pgp_pkg::PU_RST;
            i2c_en_ff <= 1'b0;
            p2_dir_ff <= pgp_pkg::P2_RST; // [R8]
            p2_data_ff <= pgp_pkg::P2_RST; // [R12]
            tsel_ff <= pgp_pkg::TSEL_RST;
        end else if (do_write & wlane_ff) begin
            if (hit(awaddr_ff, pgp_pkg::OFF_P1_DIR)) p1_dir_ff <= wbyte_ff;
            if (hit(awaddr_ff, pgp_pkg::OFF_P1_DATA)) p1_data_ff <= wbyte_ff;
            if (hit(awaddr_ff, pgp_pkg::OFF_P1_WAKE)) p1_wake_ff <= {2'b00, wbyte_ff[5:0]};
            if (hit(awaddr_ff, pgp_pkg::OFF_P1_PULLUP)) p1_pu_ff <= wbyte_ff[5:0]; // [R2]
            if (hit(awaddr_ff, pgp_pkg::OFF_I2C_CTRL)) i2c_en_ff <= wbyte_ff[pgp_pkg::I2C_EN_POS];
            if (hit(awaddr_ff, pgp_pkg::OFF_P2_DIR)) p2_dir_ff <= wbyte_ff[6:4]; // [R8]
            if (hit(awaddr_ff, pgp_pkg::OFF_P2_DATA)) p2_data_ff <= wbyte_ff[6:4];
            if (hit(awaddr_ff, pgp_pkg::OFF_TIMER_CTRL)) tsel_ff <= wbyte_ff[3:0];
        end
    end

    // Read side: data are sampled at the address handshake, so pin reads lag by one cycle.
    assign ar_take = arready_ff & arvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            araddr_ff <= 8'h00;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= pgp_pkg::RESP_OKAY;
        end else if (ar_take) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            araddr_ff <= araddr;
            rdata_ff <= {24'h00_0000, rd_byte(araddr)};
            rresp_ff <= mapped(araddr) ? pgp_pkg::RESP_OKAY : pgp_pkg::RESP_SLVERR;
        end else if (rvalid_ff) begin
            if (rready) rvalid_ff <= 1'b0;
        end else if (arvalid & ~arready_ff) begin
            arready_ff <= 1'b1;
        end
    end

    // First port pins 0 to 5: general I/O or wake input.
    genvar gi;
    generate
        for (gi = 0; gi < pgp_pkg::PU_W; gi++) begin : g_low
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    p1_oe_ff[gi] <= 1'b0; // [R13]
                    p1_out_ff[gi] <= 1'b0;
                    p1_pu_on_ff[gi] <= 1'b0;
                    wake_n_ff[gi] <= 1'b1;
                end else begin
                    p1_oe_ff[gi] <= p1_dir_ff[gi] & ~p1_wake_ff[gi]; // [R5] [R6]
                    p1_out_ff[gi] <= p1_data_ff[gi];
                    p1_pu_on_ff[gi] <= p1_pu_ff[gi] & ~p1_dir_ff[gi]; // [R1]
                    wake_n_ff[gi] <= p1_wake_ff[gi] ? p1_pin_in[gi] : 1'b1; // [R5]
                end
            end
        end
    endgenerate

    // Pins 6 and 7 are open drain while I2C owns them, so only the enable moves.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            p1_oe_ff[7:6] <= 2'b00;
            p1_out_ff[7:6] <= 2'b00;
            scl_in_ff <= 1'b1;
            sda_in_ff <= 1'b1;
            trig_n_ff <= 1'b1;
        end else begin
            trig_n_ff <= p1_wake_ff[5] ? p1_pin_in[5] : 1'b1; // [R5]
            if (i2c_en_ff) begin
                p1_oe_ff[7] <= i2c_scl_drive_low; // [R3]
                p1_oe_ff[6] <= i2c_sda_drive_low; // [R4]
                p1_out_ff[7:6] <= 2'b00;
                scl_in_ff <= p1_pin_in[7];
                sda_in_ff <= p1_pin_in[6];
            end else begin
                p1_oe_ff[7:6] <= p1_dir_ff[7:6]; // [R3] [R4] [R6]
                p1_out_ff[7:6] <= p1_data_ff[7:6];
                scl_in_ff <= 1'b1;
                sda_in_ff <= 1'b1;
            end
        end
    end

    // Second port pins 4 to 6 and the timer connections.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            p2_oe_ff <= 3'b000;
            p2_out_ff <= 3'b000;
            tclk_ff <= 1'b0;
            trst_ff <= 1'b0;
        end else begin
            p2_oe_ff[1:0] <= p2_dir_ff[1:0]; // [R8]
            p2_out_ff[1:0] <= p2_data_ff[1:0];
            if (tsel_ff != pgp_pkg::TSEL_GPIO) begin
                p2_oe_ff[2] <= 1'b1; // [R9]
                p2_out_ff[2] <= timer_output_value;
            end else begin
                p2_oe_ff[2] <= p2_dir_ff[2]; // [R9]
                p2_out_ff[2] <= p2_data_ff[2];
            end
            tclk_ff <= p2_pin_in[1]; // [R10]
            trst_ff <= p2_pin_in[0]; // [R10]
        end
    end

    assign awready = awready_ff;
    assign wready = wready_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign arready = arready_ff;
    assign rvalid = rvalid_ff;
    assign rdata = rdata_ff;
    assign rresp = rresp_ff;
    assign p1_pin_out = p1_out_ff;
    assign p1_pin_oe = p1_oe_ff;
    assign p1_pullup_on = p1_pu_on_ff;
    assign i2c_scl_in = scl_in_ff;
    assign i2c_sda_in = sda_in_ff;
    assign wake_in_n = wake_n_ff;
    assign converter_trigger_input_n = trig_n_ff;
    assign p2_pin_out = p2_out_ff;
    assign p2_pin_oe = p2_oe_ff;
    assign timer_clock_input_pin = tclk_ff;
    assign timer_reset_input_pin = trst_ff;

    property p_pullup_input_only;
        @(posedge aclk) disable iff (!aresetn) $past(aresetn) |-> ((p1_pu_on_ff & $past(p1_dir_ff[5:0])) == 6'h00);
    endproperty
    a_pullup_input_only: assert property (p_pullup_input_only) else $error("pull-up on an output pin"); // [R1]

    property p_pullup_rsvd;
        @(posedge aclk) disable iff (!aresetn) rvalid_ff && hit(araddr_ff, pgp_pkg::OFF_P1_PULLUP) |->
            rdata_ff[7:6] == 2'b00;
    endproperty
    a_pullup_rsvd: assert property (p_pullup_rsvd) else $error("pull-up reserved bits not zero"); // [R2]

    property p_scl_od;
        @(posedge aclk) disable iff (!aresetn) $past(aresetn) && $past(i2c_en_ff) |->
            !p1_out_ff[7] && p1_oe_ff[7] == $past(i2c_scl_drive_low);
    endproperty
    a_scl_od: assert property (p_scl_od) else $error("clock line not open drain"); // [R3]

    property p_sda_od;
        @(posedge aclk) disable iff (!aresetn) $past(aresetn) && $past(i2c_en_ff) |->
            !p1_out_ff[6] && p1_oe_ff[6] == $past(i2c_sda_drive_low);
    endproperty
    a_sda_od: assert property (p_sda_od) else $error("data line not open drain"); // [R4]

    property p_wake_no_drive;
        @(posedge aclk) disable iff (!aresetn) $past(aresetn) |-> ((p1_oe_ff[5:0] & $past(p1_wake_ff[5:0])) == 6'h00);
    endproperty
    a_wake_no_drive: assert property (p_wake_no_drive) else $error("wake pin driven"); // [R5]

    property p_gpio_dir;
        @(posedge aclk) disable iff (!aresetn) $past(aresetn) && !$past(i2c_en_ff) |->
            p1_oe_ff[7:6] == $past(p1_dir_ff[7:6]);
    endproperty
    a_gpio_dir: assert property (p_gpio_dir) else $error("upper pins ignore direction"); // [R6]

    property p_p1_read;
        @(posedge aclk) disable iff (!aresetn) ar_take && hit(araddr, pgp_pkg::OFF_P1_DATA) |=>
            rdata_ff[7:0] == (($past(p1_dir_ff) & $past(p1_data_ff)) | (~$past(p1_dir_ff) & $past(p1_pin_in)));
    endproperty
    a_p1_read: assert property (p_p1_read) else $error("first port read mismatch"); // [R7]

    property p_p2_dir_reset;
        @(posedge aclk) disable iff (!aresetn) !$past(aresetn) |->
            p2_dir_ff == 3'b000 && p2_data_ff == 3'b000 ##1 p2_oe_ff == 3'b000;
    endproperty
    a_p2_dir_reset: assert property (p_p2_dir_reset) else $error("second port not input after reset"); // [R8]

    property p_timer_out;
        @(posedge aclk) disable iff (!aresetn) tsel_ff != pgp_pkg::TSEL_GPIO ##1 tsel_ff != pgp_pkg::TSEL_GPIO |->
            p2_oe_ff[2] && p2_out_ff[2] == $past(timer_output_value);
    endproperty
    a_timer_out: assert property (p_timer_out) else $error("timer output not on pin"); // [R9]

    property p_timer_inputs;
        @(posedge aclk) disable iff (!aresetn) $past(aresetn) |->
            tclk_ff == $past(p2_pin_in[1]) && trst_ff == $past(p2_pin_in[0]);
    endproperty
    a_timer_inputs: assert property (p_timer_inputs) else $error("timer inputs not fed"); // [R10]

    property p_p2_read;
        @(posedge aclk) disable iff (!aresetn) ar_take && hit(araddr, pgp_pkg::OFF_P2_DATA) |=>
            rdata_ff[6:4] == (($past(p2_dir_ff) & $past(p2_data_ff)) | (~$past(p2_dir_ff) & $past(p2_pin_in)));
    endproperty
    a_p2_read: assert property (p_p2_read) else $error("second port read mismatch"); // [R11]

    property p_p2_rsvd;
        @(posedge aclk) disable iff (!aresetn) rvalid_ff && hit(araddr_ff, pgp_pkg::OFF_P2_DATA) |->
            rdata_ff[7] && rdata_ff[3:0] == 4'hf;
    endproperty
    a_p2_rsvd: assert property (p_p2_rsvd) else $error("second port reserved bits not one"); // [R12]

    property p_reset_inputs;
        @(posedge aclk) disable iff (!aresetn) !$past(aresetn) |=> p1_oe_ff == 8'h00 && p1_pu_on_ff == 6'h00;
    endproperty
    a_reset_inputs: assert property (p_reset_inputs) else $error("pins not inputs after reset"); // [R13]
endmodule
`default_nettype wire

/* sim/pgp_board.sv */
/*
 * Board model for both ports: resolves each pin level from the block's drive,
 * the external drivers and the pull-ups.
 * Lets the bench drive a pin externally while the block drives it; the block's drive wins.
 */
`timescale 1ns/1ps
`default_nettype none
module pgp_board (
    // Clock
    input wire logic aclk,
    // First port
    input wire logic [7:0] p1_pin_out,
    input wire logic [7:0] p1_pin_oe,
    input wire logic [5:0] p1_pullup_on,
    input wire logic [7:0] p1_ext_en,
    input wire logic [7:0] p1_ext_val,
    output logic [7:0] p1_pin_in,
    // Second port
    input wire logic [2:0] p2_pin_out,
    input wire logic [2:0] p2_pin_oe,
    input wire logic [2:0] p2_ext_en,
    input wire logic [2:0] p2_ext_val,
    output logic [2:0] p2_pin_in
);
    logic float_ff = 1'b0;
    logic [7:0] pu;
    // A released line without pull-up must not look stable, so it toggles every cycle.
    always_ff @(posedge aclk) begin
        float_ff <= ~float_ff;
    end
    // The block's drive wins; an open-drain low shows as 0.
    always_comb begin
        pu = {2'b00, p1_pullup_on};
        for (int i = 0; i < 8; i++) begin
            p1_pin_in[i] = p1_pin_oe[i] ? p1_pin_out[i] : p1_ext_en[i] ? p1_ext_val[i] : pu[i] | float_ff;
        end
        for (int i = 0; i < 3; i++) begin
            p2_pin_in[i] = p2_pin_oe[i] ? p2_pin_out[i] : p2_ext_en[i] ? p2_ext_val[i] : float_ff;
        end
    end
endmodule
`default_nettype wire

/* sim/port5_port7_gpio_pinmux_test.sv */
/*
 * Self-checking bench for the two-port pin block: AXI4-Lite master tasks,
 * random register settings with corner cases, and a board model on the pins.
 * Assumes the slave timing and offsets of the design package.
 */
`timescale 1ns/1ps
`default_nettype none
module port5_port7_gpio_pinmux_test;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr, p1_pin_in, p1_pin_out, p1_pin_oe, p1_ext_en, p1_ext_val;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [5:0] p1_pullup_on, wake_in_n;
    logic i2c_scl_drive_low, i2c_sda_drive_low, i2c_scl_in, i2c_sda_in, converter_trigger_input_n;
    logic timer_output_value, timer_clock_input_pin, timer_reset_input_pin;
    logic [2:0] p2_pin_in, p2_pin_out, p2_pin_oe, p2_ext_en, p2_ext_val;
    int failures, check_count, seed_dummy;

    pgp_top i_pgp_top (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .p1_pin_in, .p1_pin_out, .p1_pin_oe, .p1_pullup_on, .i2c_scl_drive_low, .i2c_sda_drive_low,
        .i2c_scl_in, .i2c_sda_in, .wake_in_n, .converter_trigger_input_n, .p2_pin_in, .p2_pin_out,
        .p2_pin_oe, .timer_output_value, .timer_clock_input_pin, .timer_reset_input_pin);
    pgp_board i_pgp_board (.aclk, .p1_pin_out, .p1_pin_oe, .p1_pullup_on, .p1_ext_en, .p1_ext_val,
        .p1_pin_in, .p2_pin_out, .p2_pin_oe, .p2_ext_en, .p2_ext_val, .p2_pin_in);

    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    function automatic logic [7:0] pick(input logic [7:0] s, input logic [7:0] a, input logic [7:0] b);
        return (s & a) | (~s & b);
    endfunction

    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Every bus wait goes through here so a stuck slave ends the run.
    task automatic tick(inout int n);
        @(posedge aclk);
        n++;
        if (n > 40) begin
            failures++;
            summarize();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = pgp_pkg::RESP_OKAY);
        int n;
        logic ad, wd;
        n = 0;
        ad = 1'b0;
        wd = 1'b0;
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ad && wd)) begin
            tick(n);
            ad = ad || awready === 1'b1;
            wd = wd || wready === 1'b1;
            awvalid <= !ad;
            wvalid <= !wd;
        end
        while (bvalid !== 1'b1) begin
            tick(n);
        end
        bready <= 1'b0;
        cmp("bresp", er, bresp);
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [1:0] er, input logic [31:0] e);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (arready !== 1'b1) begin
            tick(n);
        end
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) begin
            tick(n);
        end
        rready <= 1'b0;
        cmp("rresp", er, rresp);
        cmp("rdata", e, rdata);
        @(posedge aclk);
    endtask

    task automatic reset_and_check;
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        cmp("p1_oe", 8'h00, p1_pin_oe);
        cmp("p2_oe", 3'h0, p2_pin_oe);
        cmp("pullup", 6'h00, p1_pullup_on);
        cmp("i2c_in", 2'h3, {i2c_scl_in, i2c_sda_in});
        cmp("wake", 7'h7f, {wake_in_n, converter_trigger_input_n});
        rd(pgp_pkg::OFF_P1_DATA, pgp_pkg::RESP_OKAY, {24'h0, p1_ext_val});
        rd(pgp_pkg::OFF_P1_PULLUP, pgp_pkg::RESP_OKAY, 32'h0);
        wr(pgp_pkg::OFF_P2_DIR, 8'h70);
        rd(pgp_pkg::OFF_P2_DATA, pgp_pkg::RESP_OKAY, 32'h8f);
    endtask

    initial begin
        logic [7:0] dir, dat, pu, wk, ie, p2d, p2v, ts, eoe, elev;
        logic [2:0] e2oe, e2lev;
        seed_dummy = $urandom(32'hb747);
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata, wstrb} = 52'h0;
        {i2c_scl_drive_low, i2c_sda_drive_low, timer_output_value} = 3'h0;
        {p1_ext_en, p1_ext_val, p2_ext_en, p2_ext_val} = {8'hff, 8'ha5, 3'h7, 3'h5};
        wstrb = 4'hf;
        reset_and_check();
        for (int k = 0; k < 24; k++) begin
            dir = 8'($urandom);
            dat = 8'($urandom);
            pu = 8'($urandom);
            wk = 8'($urandom);
            ie = 8'($urandom);
            p2d = 8'($urandom);
            p2v = 8'($urandom);
            ts = k[1] ? 8'h00 : 8'($urandom);
            if (k == 0) begin
                dir = 8'hff;
                wk = 8'h3f;
                ie = 8'h01;
            end
            p1_ext_val <= 8'($urandom);
            p2_ext_val <= 3'($urandom);
            {i2c_scl_drive_low, i2c_sda_drive_low, timer_output_value} <= 3'($urandom);
            wr(pgp_pkg::OFF_P1_DIR, dir);
            wr(pgp_pkg::OFF_P1_DATA, dat);
            wr(pgp_pkg::OFF_P1_PULLUP, pu);
            wr(pgp_pkg::OFF_P1_WAKE, wk);
            wr(pgp_pkg::OFF_I2C_CTRL, ie);
            wr(pgp_pkg::OFF_P2_DIR, p2d);
            wr(pgp_pkg::OFF_P2_DATA, p2v);
            wr(pgp_pkg::OFF_TIMER_CTRL, ts);
            @(posedge aclk);
            eoe = dir & {2'b11, ~wk[5:0]};
            elev = pick(eoe, dat, p1_ext_val);
            if (ie[pgp_pkg::I2C_EN_POS]) begin
                eoe[7:6] = {i2c_scl_drive_low, i2c_sda_drive_low};
                elev[7:6] = ~eoe[7:6] & p1_ext_val[7:6];
            end
            cmp("p1_oe", eoe, p1_pin_oe);
            cmp("p1_level", elev, p1_pin_in);
            cmp("pullup", pu[5:0] & ~dir[5:0], p1_pullup_on);
            cmp("wake", {~wk[5:0] | elev[5:0], ~wk[5] | elev[5]}, {wake_in_n, converter_trigger_input_n});
            cmp("i2c_in", ie[0] ? elev[7:6] : 2'h3, {i2c_scl_in, i2c_sda_in});
            rd(pgp_pkg::OFF_P1_DATA, pgp_pkg::RESP_OKAY, {24'h0, pick(dir, dat, elev)});
            rd(pgp_pkg::OFF_P1_PULLUP, pgp_pkg::RESP_OKAY, {26'h0, pu[5:0]});
            e2oe = p2d[6:4] | {ts[3:0] != 4'h0, 2'b00};
            e2lev = 3'(pick({5'h0, e2oe}, {5'h0, p2v[6:4]}, {5'h0, p2_ext_val}));
            if (ts[3:0] != pgp_pkg::TSEL_GPIO) begin
                e2lev[2] = timer_output_value;
            end
            cmp("p2_oe", e2oe, p2_pin_oe);
            cmp("p2_level", e2lev, p2_pin_in);
            cmp("timer_in", e2lev[1:0], {timer_clock_input_pin, timer_reset_input_pin});
            rd(pgp_pkg::OFF_P2_DATA, pgp_pkg::RESP_OKAY, {24'h0, 1'b1, 3'(pick({5'h0, p2d[6:4]}, {5'h0, p2v[6:4]},
                {5'h0, e2lev})), 4'hf});
        end
        // Undriven inputs with pull-ups on must read high.
        p1_ext_en <= 8'hc0;
        wr(pgp_pkg::OFF_I2C_CTRL, 8'h00);
        wr(pgp_pkg::OFF_P1_WAKE, 8'h00);
        wr(pgp_pkg::OFF_P1_DIR, 8'h00);
        wr(pgp_pkg::OFF_P1_PULLUP, 8'hff);
        rd(pgp_pkg::OFF_P1_DATA, pgp_pkg::RESP_OKAY, {24'h0, p1_ext_val[7:6], 6'h3f});
        // A write with byte lane 0 disabled must leave the register alone.
        wstrb <= 4'h0;
        wr(pgp_pkg::OFF_P1_PULLUP, 8'h00);
        wstrb <= 4'hf;
        rd(pgp_pkg::OFF_P1_PULLUP, pgp_pkg::RESP_OKAY, 32'h3f);
        p1_ext_en <= 8'hff;
        wr(8'h20, 8'h5a, pgp_pkg::RESP_SLVERR);
        rd(8'h20, pgp_pkg::RESP_SLVERR, 32'h0);
        reset_and_check();
        summarize();
    end
endmodule
`default_nettype wire
